/* ssc_meas_model.sv */
// Purpose: Measurement front end feeding samples to the block.
// Assumes: Same clock as the block.
// Notes: Between strobes the bus toggles, so a stale value reads wrong in two of the three gap cycles.
`timescale 1ns/100ps
module ssc_meas_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Level set by the bench.
  input wire logic [19:0] level_mv,
  // Sample out.
  output logic [19:0] meas_mv,
  output logic meas_valid
);
  logic [1:0] phase;
  // One sample every fourth cycle, like a slow converter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
      meas_valid <= 1'b0;
      meas_mv <= 20'h0;
    end else begin
      phase <= phase + 2'h1;
      meas_valid <= phase == 2'h3;
      meas_mv <= (phase == 2'h3) ? level_mv : ~meas_mv;
    end
  end
endmodule

/* ssc_pkg.sv */
// Purpose: Shared constants for the supply setpoint and status command block.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes: Voltages are carried in millivolts, dwell times in 10 ms units, waits in ms.
package ssc_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_DWELL = 8'h00;
  localparam logic [7:0] OFS_VSET = 8'h04;
  localparam logic [7:0] OFS_VCEIL = 8'h08;
  localparam logic [7:0] OFS_VNOW = 8'h0c;
  localparam logic [7:0] OFS_VPEAK = 8'h10;
  localparam logic [7:0] OFS_VLOW = 8'h14;
  localparam logic [7:0] OFS_WAIT = 8'h18;
  localparam logic [7:0] OFS_CTRL = 8'h1c;
  localparam logic [7:0] OFS_COND = 8'h20;
  localparam logic [7:0] OFS_EVB = 8'h24;
  localparam logic [7:0] OFS_ESR = 8'h28;
  localparam logic [7:0] OFS_REPLY = 8'h2c;
  localparam logic [7:0] OFS_STAT = 8'h30;
  localparam logic [7:0] OFS_TRIGDEF = 8'h34;
  // Setting ranges.
  localparam logic [31:0] DWELL_MIN = 32'h0000_0001;
  localparam logic [31:0] DWELL_MAX = 32'h0000_270f;
  localparam logic [31:0] WAIT_MIN = 32'h0000_0001;
  localparam logic [31:0] WAIT_MAX = 32'h0000_270f;
  localparam logic [7:0] TRIGDEF_MAX = 8'h50;
  localparam int TRIGDEF_HAS_TRG = 8;
  // Fixed reply lengths in characters.
  localparam logic [7:0] REPLY_LEN_DWELL = 8'h0a;
  localparam logic [7:0] REPLY_LEN_VOLT = 8'h0d;
  // Event register B bits.
  localparam int EVB_OUTERR = 0;
  localparam int EVB_LIMIT = 1;
  localparam int EVB_OTA = 2;
  localparam int EVB_OTI = 3;
  localparam int EVB_OCP = 4;
  localparam int EVB_SEQ = 5;
  localparam int EVB_MACRO = 6;
  localparam int EVB_TRIG = 7;
  // Standard event register bits.
  localparam int ESR_OPC = 0;
  localparam int ESR_QYE = 2;
  localparam int ESR_EXE = 4;
  localparam int ESR_CME = 5;
  // Condition register A bits.
  localparam int COND_OCP = 1;
  localparam int COND_PLIM = 3;
  localparam int COND_OVP = 5;
  localparam int COND_OTP = 6;
  // Control register bits.
  localparam int CTRL_OUT_ON = 0;
  localparam int CTRL_OUT_OFF = 1;
  localparam int CTRL_SEQ_GO = 2;
  localparam int CTRL_OPC = 3;
  localparam int CTRL_SEQ_INIT = 4;
  localparam int CTRL_MM_CLR = 5;
  localparam int CTRL_PON_LSB = 8;
  // Status register bits.
  localparam int STAT_MAV = 0;
  localparam int STAT_SEQ_RUN = 1;
  localparam int STAT_SEQ_IDLE = 2;
  localparam int STAT_OUT_ON = 3;
  localparam int STAT_BUSY = 4;
  localparam int STAT_ERR_LSB = 8;
  // Displayed error codes (decimal 21, 22, 25, 27).
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_SEQ_LIMIT = 8'h15;
  localparam logic [7:0] ERR_SEQ_EMPTY = 8'h16;
  localparam logic [7:0] ERR_OUT_BLOCK = 8'h19;
  localparam logic [7:0] ERR_NO_INIT = 8'h1b;
  // Timing.
  localparam longint CLK_HZ = 125000000;
  localparam longint WAIT_TICK_MS = 1;
  localparam int MS_CYCLES = int'(CLK_HZ * WAIT_TICK_MS / 1000);
  localparam longint ERR_SHOW_S = 1;
  localparam int ERR_HOLD_CYCLES = int'(CLK_HZ * ERR_SHOW_S);
  // Power-on behaviour and wait engine state.
  typedef enum logic [1:0] {PON_STANDBY = 2'b00, PON_RESET = 2'b01, PON_RECALL = 2'b10} ssc_pon_type;
  typedef enum logic {RUN_IDLE = 1'b0, RUN_WAIT = 1'b1} ssc_run_type;
endpackage

/* ssc_supply_cmds.sv */
// Purpose: Setpoint, ceiling, measurement, wait and status/event handling of a programmable supply.
// Assumes: Single 125 MHz clock; pins are synchronised here, measurement and sequence inputs are same-clock.
// Notes: The wait command stalls the bus through pready, which is how the input buffer is blocked.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/100ps
////////////////////////////////////////
// How it works
// RULE_01 - Dwell time 0.01 to 99.99 s, 10 ms
// RULE_02 - Dwell query reply is 10 characters
// RULE_03 - Ceiling below setpoint refused, limit+execution errors
// RULE_04 - Requested voltages rounded to step multiple
// RULE_05 - Setpoint above ceiling refused, reset 0 V
// RULE_06 - Analog setpoint ignores the ceiling
// RULE_07 - Voltage query replies are 13 characters
// RULE_08 - Keep peak and lowest measured voltage
// RULE_09 - Wait delays 1 to 9999 ms
// RULE_10 - Host keeps chained strings within 255 characters
// RULE_11 - During wait, no processing, input blocked
// RULE_12 - Status registers reachable only over remote bus
// RULE_13 - Overheated: output-on ignored, overheat flag again
// RULE_14 - After cooling: flag, recall mode re-enables output
// RULE_15 - Off trigger blocks output-on: error 25
// RULE_16 - Sequence start aborts on error 21/22
// RULE_17 - Trigger macro over 80 or nested: error
// RULE_18 - Register reads give plain 8-bit values
// RULE_19 - Condition A bits 3,5,6: overload, overvoltage, overheat
// RULE_20 - Overcurrent trip: flag, output off until on
// RULE_21 - Message available flag; empty read: query error
// RULE_22 - Completion flag after preceding commands finish
// RULE_23 - Trigger before sequence init: error 27, flag
// RULE_24 - Refused settings leave stored values unchanged
module ssc_supply_cmds #(
  parameter int unsigned STEP_MV = 5,
  parameter int unsigned VNOM_MV = 20000,
  parameter int unsigned MS_CYCLES = ssc_pkg::MS_CYCLES,
  parameter int unsigned HOLD_CYCLES = ssc_pkg::ERR_HOLD_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous condition pins.
  input wire logic overheat_pin,
  input wire logic overcurrent_pin,
  input wire logic overvolt_pin,
  input wire logic power_limit_pin,
  input wire logic off_trigger_pin,
  input wire logic analog_trigger_pin,
  input wire logic analog_sel_pin,
  // Same-clock measurement and sequence inputs.
  input wire logic [19:0] analog_mv,
  input wire logic [19:0] meas_mv,
  input wire logic meas_valid,
  input wire logic seq_recall_over,
  input wire logic seq_range_empty,
  input wire logic seq_done,
  // Outputs to the power stage and display.
  output logic output_on,
  output logic [19:0] setpoint_mv,
  output logic seq_running,
  output logic [7:0] err_code,
  output logic display_freeze
);
  localparam logic [31:0] STEP = 32'(STEP_MV);
  localparam logic [31:0] VNOM = 32'(VNOM_MV);
  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);
  localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYCLES - 1);

  // Address match, used for every register decode.
  function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
    is_ofs = (a == o);
  endfunction

  ////////////////////////////////////////
  // State.
  ssc_pkg::ssc_run_type run_st;
  logic [13:0] dwell;
  logic [19:0] vset;
  logic [19:0] vceil;
  logic [19:0] vnow;
  logic [19:0] vpeak;
  logic [19:0] vlow;
  logic [13:0] wait_left;
  logic [31:0] ms_div;
  logic [31:0] hold_cnt;
  logic [7:0] evb;
  logic [7:0] esr;
  logic [7:0] reply_len;
  logic mav;
  logic seq_init;
  logic [1:0] pon_mode;
  logic was_on;
  logic [6:0] pin_m;
  logic [6:0] pin_s;
  logic [6:0] pin_d;

  ////////////////////////////////////////
  // Bus decode. A stalled access simply waits out the delay, so the host never loses a command.
  wire busy = (run_st == ssc_pkg::RUN_WAIT);
  wire acc = psel & penable & ~busy; // RULE_12
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire h_dwell = is_ofs(paddr, ssc_pkg::OFS_DWELL);
  wire h_vset = is_ofs(paddr, ssc_pkg::OFS_VSET);
  wire h_vceil = is_ofs(paddr, ssc_pkg::OFS_VCEIL);
  wire h_vnow = is_ofs(paddr, ssc_pkg::OFS_VNOW);
  wire h_vpeak = is_ofs(paddr, ssc_pkg::OFS_VPEAK);
  wire h_vlow = is_ofs(paddr, ssc_pkg::OFS_VLOW);
  wire h_wait = is_ofs(paddr, ssc_pkg::OFS_WAIT);
  wire h_ctrl = is_ofs(paddr, ssc_pkg::OFS_CTRL);
  wire h_cond = is_ofs(paddr, ssc_pkg::OFS_COND);
  wire h_evb = is_ofs(paddr, ssc_pkg::OFS_EVB);
  wire h_esr = is_ofs(paddr, ssc_pkg::OFS_ESR);
  wire h_reply = is_ofs(paddr, ssc_pkg::OFS_REPLY);
  wire h_stat = is_ofs(paddr, ssc_pkg::OFS_STAT);
  wire h_macro = is_ofs(paddr, ssc_pkg::OFS_TRIGDEF);
  wire hit = h_dwell | h_vset | h_vceil | h_vnow | h_vpeak | h_vlow | h_wait | h_ctrl | h_cond | h_evb | h_esr
    | h_reply | h_stat | h_macro;
  wire q_volt = h_vset | h_vceil | h_vnow | h_vpeak | h_vlow;

  // Handshake answers are combinational; the wait engine holds pready low.
  assign pready = ~busy; // RULE_11
  assign pslverr = psel & penable & ~hit;
  assign display_freeze = busy; // RULE_11

  ////////////////////////////////////////
  // Pin synchronisers; levels come from the second stage, edges from the second stage against the third.
  wire overheat_s = pin_s[0];
  wire ocp_s = pin_s[1];
  wire ovp_s = pin_s[2];
  wire plim_s = pin_s[3];
  wire off_trig_s = pin_s[4];
  wire trig_s = pin_s[5];
  wire analog_sel_s = pin_s[6];
  wire overheat_rise = overheat_s & ~pin_d[0];
  wire overheat_fall = ~overheat_s & pin_d[0];
  wire ocp_rise = ocp_s & ~pin_d[1];
  wire ovp_rise = ovp_s & ~pin_d[2];
  wire trig_rise = trig_s & ~pin_d[5];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m <= 7'h00;
      pin_s <= 7'h00;
      pin_d <= 7'h00;
    end else begin
      pin_m <= {analog_sel_pin, analog_trigger_pin, off_trigger_pin, power_limit_pin, overvolt_pin,
        overcurrent_pin, overheat_pin};
      pin_s <= pin_m;
      pin_d <= pin_s;
    end
  end

  ////////////////////////////////////////
  // Setting checks. Rounding to nearest step happens before the limit comparison.
  wire [31:0] round_mv = ((pwdata + (STEP >> 1)) / STEP) * STEP; // RULE_04
  wire over_nom = (round_mv > VNOM);
  wire vset_refused = (round_mv > {12'h000, vceil}); // RULE_05
  wire vceil_refused = (round_mv < {12'h000, vset}); // RULE_03
  wire dwell_ok = (pwdata >= ssc_pkg::DWELL_MIN) && (pwdata <= ssc_pkg::DWELL_MAX); // RULE_01
  wire wait_ok = (pwdata >= ssc_pkg::WAIT_MIN) && (pwdata <= ssc_pkg::WAIT_MAX); // RULE_09
  wire w_vset = wr & h_vset;
  wire w_vceil = wr & h_vceil;
  wire lim_err = (w_vset & ~over_nom & vset_refused) | (w_vceil & ~over_nom & vceil_refused);
  wire range_err = ((w_vset | w_vceil) & over_nom) | (wr & h_dwell & ~dwell_ok) | (wr & h_wait & ~wait_ok);
  wire vset_take = w_vset & ~over_nom & ~vset_refused; // RULE_24
  wire vceil_take = w_vceil & ~over_nom & ~vceil_refused; // RULE_24
  wire wait_start = wr & h_wait & wait_ok;
  wire ms_tick = (ms_div == MS_LAST);

  // Control strobes.
  wire c_on = wr & h_ctrl & pwdata[ssc_pkg::CTRL_OUT_ON];
  wire c_off = wr & h_ctrl & pwdata[ssc_pkg::CTRL_OUT_OFF];
  wire c_go = wr & h_ctrl & pwdata[ssc_pkg::CTRL_SEQ_GO];
  wire c_opc = wr & h_ctrl & pwdata[ssc_pkg::CTRL_OPC];
  wire c_mmclr = wr & h_ctrl & pwdata[ssc_pkg::CTRL_MM_CLR];
  wire macro_bad = wr & h_macro & ((pwdata[7:0] > ssc_pkg::TRIGDEF_MAX) | pwdata[ssc_pkg::TRIGDEF_HAS_TRG]);
  wire seq_abort = c_go & (seq_recall_over | seq_range_empty); // RULE_16
  wire no_init_trig = trig_rise & ~seq_init; // RULE_23
  wire on_blocked_heat = c_on & overheat_s; // RULE_13
  wire on_blocked_trig = c_on & ~overheat_s & off_trig_s; // RULE_15

  ////////////////////////////////////////
  // Event sets and clears. A set wins; a read clears only the bits it returned, so late events survive.
  logic [7:0] evb_set;
  logic [7:0] esr_set;
  logic [7:0] cond;
  always_comb begin
    evb_set = 8'h00;
    evb_set[ssc_pkg::EVB_LIMIT] = lim_err; // RULE_03
    evb_set[ssc_pkg::EVB_OUTERR] = on_blocked_trig; // RULE_15
    evb_set[ssc_pkg::EVB_OTA] = overheat_rise | on_blocked_heat; // RULE_13
    evb_set[ssc_pkg::EVB_OTI] = overheat_fall; // RULE_14
    evb_set[ssc_pkg::EVB_OCP] = ocp_rise; // RULE_20
    evb_set[ssc_pkg::EVB_SEQ] = seq_abort | no_init_trig; // RULE_16
    evb_set[ssc_pkg::EVB_MACRO] = macro_bad; // RULE_17
    evb_set[ssc_pkg::EVB_TRIG] = trig_rise;
    esr_set = 8'h00;
    esr_set[ssc_pkg::ESR_EXE] = lim_err; // RULE_03
    esr_set[ssc_pkg::ESR_CME] = range_err;
    esr_set[ssc_pkg::ESR_QYE] = rd & h_reply & ~mav; // RULE_21
    // Every command executes in its own access and the bus stalls through a wait,
    // so by the time this write is taken all earlier commands are done.
    esr_set[ssc_pkg::ESR_OPC] = c_opc; // RULE_22
    cond = 8'h00;
    cond[ssc_pkg::COND_OCP] = ocp_s;
    cond[ssc_pkg::COND_PLIM] = plim_s; // RULE_19
    cond[ssc_pkg::COND_OVP] = ovp_s; // RULE_19
    cond[ssc_pkg::COND_OTP] = overheat_s; // RULE_19
  end

  wire [7:0] evb_clr = (rd & h_evb) ? prdata[7:0] : 8'h00;
  wire [7:0] esr_clr = (rd & h_esr) ? prdata[7:0] : 8'h00;
  wire [7:0] next_evb = (evb & ~evb_clr) | evb_set;
  wire [7:0] next_esr = (esr & ~esr_clr) | esr_set;

  ////////////////////////////////////////
  // Read data. Register values are plain binary in the low bits; the host prints them in decimal.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      h_dwell: rd_mux = {18'h00000, dwell};
      h_vset: rd_mux = {12'h000, vset};
      h_vceil: rd_mux = {12'h000, vceil};
      h_vnow: rd_mux = {12'h000, vnow};
      h_vpeak: rd_mux = {12'h000, vpeak}; // RULE_08
      h_vlow: rd_mux = {12'h000, vlow}; // RULE_08
      h_wait: rd_mux = {18'h00000, wait_left};
      h_ctrl: rd_mux = {22'h000000, pon_mode, 3'h0, seq_init, 4'h0};
      h_cond: rd_mux = {24'h000000, cond}; // RULE_18
      h_evb: rd_mux = {24'h000000, evb}; // RULE_18
      h_esr: rd_mux = {24'h000000, esr}; // RULE_18
      h_reply: rd_mux = {24'h000000, mav ? reply_len : 8'h00};
      h_stat: rd_mux = {16'h0000, err_code, 3'h0, busy, output_on, ~seq_running, seq_running, mav};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is captured while the request is held, so it is stable at the completing edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel) begin
      prdata <= rd_mux;
    end
  end

  ////////////////////////////////////////
  // Settings. The ceiling resets to nominal and the setpoint to zero; refused writes change nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dwell <= 14'h0000;
      vset <= 20'h00000; // RULE_05
      vceil <= 20'(VNOM_MV);
      seq_init <= 1'b0;
      pon_mode <= ssc_pkg::PON_STANDBY;
    end else begin
      if (wr & h_dwell & dwell_ok) dwell <= pwdata[13:0]; // RULE_01
      if (vset_take) vset <= round_mv[19:0]; // RULE_05
      if (vceil_take) vceil <= round_mv[19:0]; // RULE_03
      if (wr & h_ctrl) begin
        seq_init <= pwdata[ssc_pkg::CTRL_SEQ_INIT];
        pon_mode <= pwdata[ssc_pkg::CTRL_PON_LSB +: 2];
      end
    end
  end

  // Analog control overrides the programmed setpoint with no ceiling check.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setpoint_mv <= 20'h00000;
    end else begin
      setpoint_mv <= analog_sel_s ? analog_mv : vset; // RULE_06
    end
  end

  ////////////////////////////////////////
  // Measurement tracking, frozen while a wait is running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vnow <= 20'h00000;
      vpeak <= 20'h00000;
      vlow <= 20'hfffff;
    end else if (c_mmclr) begin
      vpeak <= vnow;
      vlow <= vnow;
    end else if (meas_valid & ~busy) begin // RULE_11
      vnow <= meas_mv;
      if (meas_mv > vpeak) vpeak <= meas_mv; // RULE_08
      if (meas_mv < vlow) vlow <= meas_mv; // RULE_08
    end
  end

  ////////////////////////////////////////
  // Wait engine: counts whole milliseconds from the end of the wait write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_st <= ssc_pkg::RUN_IDLE;
      wait_left <= 14'h0000;
      ms_div <= 32'h0000_0000;
    end else begin
      case (run_st)
        ssc_pkg::RUN_IDLE: begin
          ms_div <= 32'h0000_0000;
          if (wait_start) begin
            wait_left <= pwdata[13:0]; // RULE_09
            run_st <= ssc_pkg::RUN_WAIT;
          end
        end
        ssc_pkg::RUN_WAIT: begin
          ms_div <= ms_tick ? 32'h0000_0000 : ms_div + 32'h0000_0001;
          if (ms_tick) begin
            wait_left <= wait_left - 14'h0001;
            if (wait_left == 14'h0001) run_st <= ssc_pkg::RUN_IDLE; // RULE_11
          end
        end
        default: run_st <= ssc_pkg::RUN_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////
  // Event registers, reply bookkeeping and message-available flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evb <= 8'h00;
      esr <= 8'h00;
      mav <= 1'b0;
      reply_len <= 8'h00;
    end else begin
      evb <= next_evb;
      esr <= next_esr;
      if (rd & (q_volt | h_dwell)) begin
        mav <= 1'b1; // RULE_21
        reply_len <= h_dwell ? ssc_pkg::REPLY_LEN_DWELL : ssc_pkg::REPLY_LEN_VOLT; // RULE_02 RULE_07
      end else if (rd & h_reply) begin
        mav <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////
  // Output switch. Protection trips win over a same-cycle on command.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_on <= 1'b0;
      was_on <= 1'b0;
    end else if (overheat_rise) begin
      was_on <= output_on;
      output_on <= 1'b0;
    end else if (ocp_rise | ovp_rise) begin
      output_on <= 1'b0; // RULE_20
    end else if (overheat_fall) begin
      output_on <= (pon_mode == ssc_pkg::PON_RECALL) & was_on; // RULE_14
    end else if (c_off) begin
      output_on <= 1'b0;
    end else if (c_on & ~overheat_s & ~off_trig_s) begin // RULE_13 RULE_15
      output_on <= 1'b1; // RULE_20
    end
  end

  ////////////////////////////////////////
  // Sequence start checks and run flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_running <= 1'b0;
    end else if (c_go) begin
      seq_running <= ~seq_abort; // RULE_16
    end else if (seq_done) begin
      seq_running <= 1'b0;
    end
  end

  // Displayed error code, shown for the hold time after its cause.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_code <= ssc_pkg::ERR_NONE;
      hold_cnt <= 32'h0000_0000;
    end else if (no_init_trig | seq_abort | on_blocked_trig) begin
      hold_cnt <= 32'h0000_0000;
      if (no_init_trig) err_code <= ssc_pkg::ERR_NO_INIT; // RULE_23
      else if (seq_abort & seq_recall_over) err_code <= ssc_pkg::ERR_SEQ_LIMIT; // RULE_16
      else if (seq_abort) err_code <= ssc_pkg::ERR_SEQ_EMPTY; // RULE_16
      else err_code <= ssc_pkg::ERR_OUT_BLOCK; // RULE_15
    end else if (err_code != ssc_pkg::ERR_NONE) begin
      hold_cnt <= hold_cnt + 32'h0000_0001;
      if (hold_cnt == HOLD_LAST) err_code <= ssc_pkg::ERR_NONE; // RULE_23
    end
  end
endmodule

/* ssc_supply_cmds_asserts.sv */
// Purpose: Port-level assertions for the supply setpoint and status block.
// Assumes: Bench parameters MS_CYCLES 4 and HOLD_CYCLES 16.
// Notes: Delay windows below are sized for those two values.
`timescale 1ns/100ps
module ssc_supply_cmds_asserts #(
  parameter int unsigned MS_CYCLES = 4,
  parameter int unsigned HOLD_CYCLES = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins.
  input wire logic overheat_pin,
  input wire logic off_trigger_pin,
  input wire logic analog_sel_pin,
  input wire logic [19:0] analog_mv,
  input wire logic seq_recall_over,
  input wire logic seq_range_empty,
  // Outputs.
  input wire logic output_on,
  input wire logic [19:0] setpoint_mv,
  input wire logic [7:0] err_code,
  input wire logic display_freeze
);
  // Completed writes and the control strobes they carry.
  wire wr_done = psel && penable && pready && pwrite;
  wire go_cmd = wr_done && paddr == 8'h1c && pwdata[2];
  wire on_cmd = wr_done && paddr == 8'h1c && pwdata[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_unmapped_err: assert property (psel && penable && paddr > 8'h34 |-> pslverr)
    else $error("unmapped access not refused");
  a_wait_stall: assert property (wr_done && paddr == 8'h18 && pwdata == 32'h3 |=>
    !pready [*8] ##[3:5] pready) else $error("wait delay wrong");
  a_freeze_busy: assert property (display_freeze == !pready)
    else $error("display not frozen with bus");
  a_setpoint_kept: assert property (wr_done && paddr == 8'h04 && pwdata > 32'h4e22 && !analog_sel_pin |=>
    $stable(setpoint_mv) [*4]) else $error("refused setpoint applied");
  a_analog_track: assert property ((analog_sel_pin && $stable(analog_mv)) [*6] |->
    setpoint_mv == analog_mv) else $error("analog setpoint not followed");
  a_seq_limit: assert property (go_cmd && seq_recall_over |-> ##[1:3] err_code == 8'h15)
    else $error("limit abort code missing");
  a_seq_empty: assert property (go_cmd && !seq_recall_over && seq_range_empty |->
    ##[1:3] err_code == 8'h16) else $error("empty range code missing");
  a_out_blocked: assert property (off_trigger_pin [*4] ##1 (on_cmd && off_trigger_pin) |->
    ##[1:3] err_code == 8'h19) else $error("blocked output code missing");
  a_overheat_off: assert property (overheat_pin [*6] |-> !output_on)
    else $error("output on while overheated");
  a_err_clears: assert property ($rose(err_code != 8'h00) |-> ##[12:20] err_code == 8'h00)
    else $error("error display time wrong");
  // Main scenarios reached.
  cover property (go_cmd && !seq_recall_over && !seq_range_empty);
  cover property (on_cmd && overheat_pin);
  cover property (!pready ##1 pready);
endmodule
////////////////////////////////////////
bind ssc_supply_cmds ssc_supply_cmds_asserts #(.MS_CYCLES(MS_CYCLES), .HOLD_CYCLES(HOLD_CYCLES))
  ssc_supply_cmds_asserts_i (.*);

/* tb_top.sv */
// Purpose: Self-checking bench for the supply setpoint and status block.
// Assumes: Short wait and display counts so the run stays brief.
// Notes: Registers go over APB; condition pins are driven directly.
`timescale 1ns/100ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sl, meas_valid, output_on, seq_running;
  logic overheat_pin, overcurrent_pin, overvolt_pin, power_limit_pin, off_trigger_pin, display_freeze;
  logic analog_trigger_pin, analog_sel_pin, seq_recall_over, seq_range_empty, seq_done;
  logic [7:0] paddr, err_code;
  logic [19:0] analog_mv, meas_mv, level_mv, setpoint_mv;
  logic [31:0] pwdata, prdata, rdat;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  int t0;
  ssc_supply_cmds #(.MS_CYCLES(4), .HOLD_CYCLES(16)) ssc_supply_cmds_i (.*);
  ssc_meas_model ssc_meas_model_i (.*);
  ////////////////////////////////////////
  // Clock, and a cycle count that cuts a hang short.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      summarize();
    end
  end
  // Compare and report.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Main sequence; pins change right after an edge.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, seq_done} = '0;
    {overheat_pin, overcurrent_pin, overvolt_pin, power_limit_pin, off_trigger_pin} = '0;
    {analog_trigger_pin, analog_sel_pin, seq_recall_over, seq_range_empty} = '0;
    analog_mv = 20'h61a8;
    level_mv = 20'h3e8;
    presetn = 1'b0;
    idle(2);
    presetn <= 1'b1;
    rc(8'h04, 32'h0);
    rc(8'h08, 32'h4e20);
    wr(8'h00, 32'h1);
    rc(8'h00, 32'h1);
    rc(8'h2c, 32'ha);
    rc(8'h2c, 32'h0);
    rc(8'h28, 32'h4);
    wr(8'h00, 32'h270f);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h2710);
    rc(8'h00, 32'h270f);
    rc(8'h28, 32'h20);
    wr(8'h04, 32'h30d6);
    rc(8'h04, 32'h30d4);
    rc(8'h2c, 32'hd);
    wr(8'h08, 32'h2ee0);
    rc(8'h24, 32'h2);
    rc(8'h28, 32'h10);
    rc(8'h08, 32'h4e20);
    wr(8'h08, 32'h3a98);
    wr(8'h04, 32'h4e23);
    wr(8'h04, 32'h3a9d);
    rc(8'h24, 32'h2);
    rc(8'h28, 32'h30);
    rc(8'h04, 32'h30d4);
    chk({12'h0, setpoint_mv}, 32'h30d4);
    level_mv <= 20'hbb8;
    idle(8);
    level_mv <= 20'h7d0;
    idle(8);
    rc(8'h0c, 32'h7d0);
    rc(8'h10, 32'hbb8);
    rc(8'h14, 32'h3e8);
    t0 = cyc;
    wr(8'h18, 32'h3);
    wr(8'h04, 32'h3e8);
    chk({31'h0, cyc - t0 > 12}, 32'h1);
    wr(8'h1c, 32'h201);
    idle(2);
    chk({31'h0, output_on}, 32'h1);
    overheat_pin <= 1'b1;
    idle(8);
    chk({31'h0, output_on}, 32'h0);
    rc(8'h20, 32'h40);
    wr(8'h1c, 32'h201);
    rc(8'h24, 32'h4);
    overheat_pin <= 1'b0;
    idle(8);
    chk({31'h0, output_on}, 32'h1);
    rc(8'h24, 32'h8);
    {overcurrent_pin, overvolt_pin, power_limit_pin} <= 3'h7;
    idle(8);
    rc(8'h20, 32'h2a);
    rc(8'h24, 32'h10);
    chk({31'h0, output_on}, 32'h0);
    {overcurrent_pin, overvolt_pin, power_limit_pin} <= 3'h0;
    idle(4);
    wr(8'h1c, 32'h1);
    idle(2);
    chk({31'h0, output_on}, 32'h1);
    wr(8'h1c, 32'h2);
    off_trigger_pin <= 1'b1;
    idle(6);
    wr(8'h1c, 32'h1);
    idle(2);
    chk({24'h0, err_code}, 32'h19);
    rc(8'h24, 32'h1);
    off_trigger_pin <= 1'b0;
    // Both sequence aborts: limit first, then empty range.
    for (int i = 0; i < 2; i++) begin
      {seq_recall_over, seq_range_empty} <= (i == 0) ? 2'b11 : 2'b01;
      idle(20);
      wr(8'h1c, 32'h4);
      idle(2);
      chk({24'h0, err_code}, (i == 0) ? 32'h15 : 32'h16);
      rc(8'h24, 32'h20);
    end
    idle(20);
    analog_trigger_pin <= 1'b1;
    idle(8);
    chk({24'h0, err_code}, 32'h1b);
    rc(8'h24, 32'ha0);
    {analog_trigger_pin, seq_range_empty} <= 2'b00;
    wr(8'h1c, 32'h14);
    idle(2);
    chk({31'h0, seq_running}, 32'h1);
    wr(8'h34, 32'h51);
    rc(8'h24, 32'h40);
    wr(8'h34, 32'h150);
    rc(8'h24, 32'h40);
    wr(8'h34, 32'h50);
    rc(8'h24, 32'h0);
    wr(8'h1c, 32'h8);
    rc(8'h28, 32'h1);
    analog_sel_pin <= 1'b1;
    idle(8);
    chk({12'h0, setpoint_mv}, 32'h61a8);
    xfer(1'b0, 8'h38, 32'h0);
    chk({31'h0, sl}, 32'h1);
    chk(rdat, 32'h0);
    summarize();
  end
endmodule
